// ### logic/div_unit.v
/*
  Iterative restoring divider, one quotient bit per clock.
  Assumes start is only raised while busy is low.
*/
`timescale 1ns/10ps
module div_unit #(
  parameter W  = 32,
  parameter CW = 6
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         start,
  input  wire         sgn,
  input  wire [W-1:0] dvd,
  input  wire [W-1:0] dvs,
  output wire         busy,
  output reg          done_q,
  output reg  [W-1:0] quo_q,
  output reg  [W-1:0] rem_q
);
  reg  [CW-1:0] cnt_q;
  reg  [W-1:0]  rq, qq, dq;
  reg           negq_q, negr_q;
  wire [W-1:0]  one = {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0]  a_abs = (sgn & dvd[W-1]) ? (~dvd + one) : dvd;
  wire [W-1:0]  b_abs = (sgn & dvs[W-1]) ? (~dvs + one) : dvs;
  // one trial subtraction per cycle
  wire [W:0]    sh = {rq, qq[W-1]};
  wire [W:0]    diff = sh - {1'b0, dq};
  wire [W-1:0]  nr = diff[W] ? sh[W-1:0] : diff[W-1:0];
  wire [W-1:0]  nq = {qq[W-2:0], ~diff[W]};
  assign busy = (cnt_q != {CW{1'b0}});
  // signs restored on the final step so outputs stay registered
  always @(posedge clk) begin
    done_q <= 1'b0;
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      rq <= {W{1'b0}};
      qq <= {W{1'b0}};
      dq <= {W{1'b0}};
      negq_q <= 1'b0;
      negr_q <= 1'b0;
      quo_q <= {W{1'b0}};
      rem_q <= {W{1'b0}};
    end else if (start && !busy) begin
      cnt_q <= W[CW-1:0];
      rq <= {W{1'b0}};
      qq <= a_abs;
      dq <= b_abs;
      negq_q <= sgn & (dvd[W-1] ^ dvs[W-1]);
      negr_q <= sgn & dvd[W-1];
    end else if (busy) begin
      rq <= nr;
      qq <= nq;
      cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      if (cnt_q == {{(CW-1){1'b0}}, 1'b1}) begin
        done_q <= 1'b1;
        quo_q <= negq_q ? (~nq + one) : nq;
        rem_q <= negr_q ? (~nr + one) : nr;
      end
    end
  end
endmodule

// ### logic/isa_exec_map.vh
/*
  Opcode fields, encodings, status bit positions and reset values
  for the instruction execution unit. Included by its bare name.
*/
`ifndef ISA_EXEC_MAP_VH
`define ISA_EXEC_MAP_VH
// primary opcodes, instruction bits 31:26
`define OP_SPECIAL   6'h00
`define OP_REGIMM    6'h01
`define OP_BEQ       6'h04
`define OP_BNE       6'h05
`define OP_BRANCH_IF_NONPOS      6'h06
`define OP_BRANCH_IF_POS      6'h07
`define OP_SIGNED_SUM_IMM_OP      6'h08
`define OP_WRAPPING_SUM_IMM_OP     6'h09
`define OP_CONJUNCTION_IMM_OP      6'h0C
`define OP_COP0      6'h10
`define OP_SECOND_COPROCESSOR      6'h12
`define OP_BEQL      6'h14
`define OP_BNEL      6'h15
`define OP_BLEZL     6'h16
`define OP_BGTZL     6'h17
`define OP_SPECIAL2  6'h1C
`define OP_SPECIAL3  6'h1F
`define OP_LINKLOAD  6'h30
// function codes, bits 5:0
`define FN_SHIFTL    6'h00
`define FN_DIV       6'h1A
`define FN_UNSIGNED_QUOTIENT_OP      6'h1B
`define FN_ADD       6'h20
`define FN_WRAPPING_SUM_OP      6'h21
`define FN_AND       6'h24
`define FN_CNT_ZERO  6'h20
`define FN_CNT_ONE   6'h21
`define FN_PULL      6'h00
`define FN_DEPOSIT   6'h04
`define FN_EXCEPTION_RETURN_OP      6'h18
`define FN_DEBUG_RETURN_OP     6'h1F
// barrier is a shift of r0 by this amount
`define SA_BARRIER   5'h03
// regimm rt field: bit 4 link, bit 1 likely, bit 0 nonneg
`define RT_LINK_BIT  4
`define RT_LIKE_BIT  1
`define RT_SIGN_BIT  0
// coprocessor rs field
`define RS_CTRL_RD   5'h02
`define RS_CTRL_WR   5'h06
`define RS_MFMC0     5'h0B
`define RS_BC_HI     2'h1
// branch-on-condition rt bits and cc field
`define BC_TF_BIT    16
`define BC_ND_BIT    17
`define BC_CC_LSB    18
`define MFMC_SC_BIT  5
// status word bits
`define ST_IE        0
`define ST_EXL       1
`define ST_ERL       2
`define STATUS_RST   32'h00000004
`define PC_RST       32'h00000000
`define LINK_REG     5'h1F
`define LINK_OFS     32'h00000008
`define STEP_OFS     32'h00000004
`endif

// ### logic/isa_exec_unit.v
/*
  Execution unit for the add, logical, branch, second coprocessor,
  divide, barrier, return, interrupt, count and bit-field subset.
  Assumes the instruction source presents the word for FETCH_PC
  with INSTR_VALID on the same clock, and that the second
  coprocessor answers a control read in the cycle CP2_CTRL_RD is high.
*/
`timescale 1ns/10ps
`include "isa_exec_map.vh"
module isa_exec_unit #(
  parameter RESET_PC = `PC_RST
) (
  input  wire        REF_CLK,
  input  wire        SRST,
  output wire [31:0] FETCH_PC,
  input  wire        INSTR_VALID,
  input  wire [31:0] INSTR_WORD,
  output wire        INSTR_READY,
  input  wire [7:0]  CP2_COND,
  output reg         CP2_CTRL_WR,
  output reg         CP2_CTRL_RD,
  output reg  [4:0]  CP2_CTRL_SEL,
  output reg  [31:0] CP2_CTRL_WDATA,
  input  wire [31:0] CP2_CTRL_RDATA,
  input  wire [31:0] EXC_RET_PC,
  input  wire [31:0] ERR_RET_PC,
  input  wire [31:0] DBG_RET_PC,
  input  wire        DEBUG_ENTER,
  output reg         DEBUG_MODE,
  input  wire        HAZARD_BUSY,
  input  wire        STATUS_LOAD,
  input  wire [31:0] STATUS_DATA,
  output reg  [31:0] STATUS_WORD,
  output reg         RESERVE_FLAG,
  output reg  [31:0] RESERVE_ADDR,
  output reg         EXC_OVERFLOW,
  output reg  [31:0] RESULT_TOP,
  output reg  [31:0] RESULT_BOTTOM,
  input  wire [4:0]  REG_SEL,
  output reg  [31:0] REG_DATA
);
  localparam ST_RUN = 2'b00;
  localparam ST_DIV = 2'b01;
  localparam ST_CP2 = 2'b10;
  localparam ST_HAZ = 2'b11;

  reg  [1:0]  state_q;
  reg  [31:0] pc_q, tgt_q;
  reg         br_pend_q, skip_q;
  reg  [4:0]  cp2_dst_q;
  reg  [31:0] gpr_q [0:31];
  integer     k;

  // instruction fields
  wire [31:0] w = INSTR_WORD;
  wire [5:0]  op = w[31:26];
  wire [4:0]  rs = w[25:21];
  wire [4:0]  rt = w[20:16];
  wire [4:0]  rd = w[15:11];
  wire [4:0]  sa = w[10:6];
  wire [5:0]  fn = w[5:0];
  wire [15:0] imm = w[15:0];
  wire [31:0] rs_v = (rs == 5'h00) ? 32'h00000000 : gpr_q[rs];
  wire [31:0] rt_v = (rt == 5'h00) ? 32'h00000000 : gpr_q[rt];
  wire [31:0] sext = {{16{imm[15]}}, imm};
  wire [31:0] boff = {{14{imm[15]}}, imm, 2'b00};
  wire [31:0] pc4 = pc_q + `STEP_OFS;
  wire [31:0] pc8 = pc_q + `LINK_OFS;
  wire [31:0] nxt = br_pend_q ? tgt_q : pc4;
  wire        take = INSTR_VALID && (state_q == ST_RUN);
  wire        live = take && !skip_q;
  wire        div_done;
  wire [31:0] div_q, div_r;

  assign FETCH_PC = pc_q;
  assign INSTR_READY = (state_q == ST_RUN);

  // leading run of bit b from the top
  function [31:0] lead_cnt;
    input [31:0] v;
    input        b;
    integer      i;
    reg          stop;
    begin
      lead_cnt = 32'h00000000;
      stop = 1'b0;
      for (i = 31; i >= 0; i = i - 1) begin
        if (!stop && (v[i] == b))
          lead_cnt = lead_cnt + 32'h00000001;
        else
          stop = 1'b1;
      end
    end
  endfunction

  // ones in bits 0 through hi
  function [31:0] low_mask;
    input [4:0] hi;
    integer     i;
    begin
      low_mask = 32'h00000000;
      for (i = 0; i < 32; i = i + 1)
        low_mask[i] = (i <= hi);
    end
  endfunction

  reg        is_br, likely, cond, wen, ovf, dstart, dsgn;
  reg        cp2r, cp2w, exec_hazard_barrier, exception_return_op, debug_return_op, llop, st_we;
  reg [4:0]  wa;
  reg [31:0] wd, st_d, s32, fm;

  // decode and operate
  always @* begin
    is_br = 1'b0;
    likely = 1'b0;
    cond = 1'b0;
    wen = 1'b0;
    wa = rd;
    wd = 32'h00000000;
    ovf = 1'b0;
    dstart = 1'b0;
    dsgn = 1'b0;
    cp2r = 1'b0;
    cp2w = 1'b0;
    exec_hazard_barrier = 1'b0;
    exception_return_op = 1'b0;
    debug_return_op = 1'b0;
    llop = 1'b0;
    st_we = 1'b0;
    st_d = STATUS_WORD;
    s32 = 32'h00000000;
    fm = 32'h00000000;
    case (op)
      `OP_SPECIAL: begin
        case (fn)
          `FN_ADD, `FN_WRAPPING_SUM_OP: begin
            s32 = rs_v + rt_v;
            ovf = (fn == `FN_ADD) && (rs_v[31] == rt_v[31]) && (s32[31] != rs_v[31]);
            wen = !ovf;
            wd = s32;
          end
          `FN_AND: begin
            wen = 1'b1;
            wd = rs_v & rt_v;
          end
          `FN_DIV, `FN_UNSIGNED_QUOTIENT_OP: begin
            dstart = 1'b1;
            dsgn = (fn == `FN_DIV);
          end
          `FN_SHIFTL: begin
            exec_hazard_barrier = (w[25:11] == 15'h0000) && (sa == `SA_BARRIER);
          end
          default: wen = 1'b0;
        endcase
      end
      `OP_SIGNED_SUM_IMM_OP, `OP_WRAPPING_SUM_IMM_OP: begin
        // immediate add, trap only on signed form
        s32 = rs_v + sext;
        ovf = (op == `OP_SIGNED_SUM_IMM_OP) && (rs_v[31] == sext[31]) && (s32[31] != rs_v[31]);
        wen = !ovf;
        wa = rt;
        wd = s32;
      end
      `OP_CONJUNCTION_IMM_OP: begin
        wen = 1'b1;
        wa = rt;
        wd = rs_v & {16'h0000, imm};
      end
      `OP_BEQ, `OP_BNE, `OP_BEQL, `OP_BNEL: begin
        is_br = 1'b1;
        likely = op[4];
        cond = (rs_v == rt_v) ^ op[0];
      end
      `OP_BRANCH_IF_NONPOS, `OP_BRANCH_IF_POS, `OP_BLEZL, `OP_BGTZL: begin
        is_br = 1'b1;
        likely = op[4];
        cond = (rs_v[31] || (rs_v == 32'h00000000)) ^ op[0];
      end
      `OP_REGIMM: begin
        is_br = (rt[3:2] == 2'b00);
        likely = rt[`RT_LIKE_BIT];
        cond = rs_v[31] ^ rt[`RT_SIGN_BIT];
        wen = is_br && rt[`RT_LINK_BIT];
        wa = `LINK_REG;
        wd = pc8;
      end
      `OP_SECOND_COPROCESSOR: begin
        if (rs[4:3] == `RS_BC_HI) begin
          is_br = 1'b1;
          likely = rt[`BC_ND_BIT - 16];
          cond = CP2_COND[w[20:18]] == w[`BC_TF_BIT];
        end
        cp2r = (rs == `RS_CTRL_RD);
        cp2w = (rs == `RS_CTRL_WR);
      end
      `OP_COP0: begin
        exception_return_op = rs[4] && (fn == `FN_EXCEPTION_RETURN_OP);
        debug_return_op = rs[4] && (fn == `FN_DEBUG_RETURN_OP);
        if (rs == `RS_MFMC0) begin
          // old status out, then enable bit
          wen = 1'b1;
          wa = rt;
          wd = STATUS_WORD;
          st_we = 1'b1;
          st_d[`ST_IE] = w[`MFMC_SC_BIT];
        end
        if (exception_return_op) begin
          st_we = 1'b1;
          st_d[`ST_EXL] = 1'b0;
          st_d[`ST_ERL] = 1'b0;
        end
      end
      `OP_SPECIAL2: begin
        wen = (fn == `FN_CNT_ZERO) || (fn == `FN_CNT_ONE);
        wd = lead_cnt(rs_v, fn[0]);
      end
      `OP_SPECIAL3: begin
        wa = rt;
        if (fn == `FN_PULL) begin
          wen = 1'b1;
          wd = (rs_v >> sa) & low_mask(rd);
        end else if (fn == `FN_DEPOSIT) begin
          wen = 1'b1;
          fm = low_mask(rd) & ~((sa == 5'h00) ? 32'h00000000 : low_mask(sa - 5'h01));
          wd = (rt_v & ~fm) | ((rs_v << sa) & fm);
        end
      end
      `OP_LINKLOAD: llop = 1'b1;
      default: wen = 1'b0;
    endcase
  end

  // register file, r0 never written
  always @(posedge REF_CLK) begin
    if (SRST) begin
      for (k = 0; k < 32; k = k + 1)
        gpr_q[k] <= 32'h00000000;
    end else if (live && wen && (wa != 5'h00)) begin
      gpr_q[wa] <= wd;
    end else if ((state_q == ST_CP2) && (cp2_dst_q != 5'h00)) begin
      gpr_q[cp2_dst_q] <= CP2_CTRL_RDATA;
    end
  end

  // program counter, delay slot and nullify
  always @(posedge REF_CLK) begin
    if (SRST) begin
      pc_q <= RESET_PC;
      tgt_q <= 32'h00000000;
      br_pend_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (take && skip_q) begin
      skip_q <= 1'b0;
      pc_q <= pc4;
    end else if (live) begin
      br_pend_q <= 1'b0;
      pc_q <= nxt;
      if (exception_return_op) begin
        // error pc when error level set
        pc_q <= STATUS_WORD[`ST_ERL] ? ERR_RET_PC : EXC_RET_PC;
      end else if (debug_return_op) begin
        pc_q <= DBG_RET_PC;
      end else if (is_br && cond) begin
        br_pend_q <= 1'b1;
        tgt_q <= pc4 + boff;
      end else if (is_br && likely) begin
        // not taken likely kills the slot
        skip_q <= 1'b1;
      end
    end
  end

  // issue stalls for divide, coprocessor read and barrier
  always @(posedge REF_CLK) begin
    if (SRST) begin
      state_q <= ST_RUN;
      cp2_dst_q <= 5'h00;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (live && dstart)
            state_q <= ST_DIV;
          else if (live && cp2r) begin
            state_q <= ST_CP2;
            cp2_dst_q <= rt;
          end else if (live && exec_hazard_barrier)
            state_q <= ST_HAZ;
        end
        ST_DIV: if (div_done) state_q <= ST_RUN;
        ST_CP2: state_q <= ST_RUN;
        ST_HAZ: if (!HAZARD_BUSY) state_q <= ST_RUN;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // architectural side state and strobes
  always @(posedge REF_CLK) begin
    if (SRST) begin
      STATUS_WORD <= `STATUS_RST;
      RESERVE_FLAG <= 1'b0;
      RESERVE_ADDR <= 32'h00000000;
      DEBUG_MODE <= 1'b0;
      EXC_OVERFLOW <= 1'b0;
      RESULT_TOP <= 32'h00000000;
      RESULT_BOTTOM <= 32'h00000000;
      CP2_CTRL_WR <= 1'b0;
      CP2_CTRL_RD <= 1'b0;
      CP2_CTRL_SEL <= 5'h00;
      CP2_CTRL_WDATA <= 32'h00000000;
      REG_DATA <= 32'h00000000;
    end else begin
      REG_DATA <= (REG_SEL == 5'h00) ? 32'h00000000 : gpr_q[REG_SEL];
      EXC_OVERFLOW <= live && ovf;
      // write strobe, read level for one cycle
      CP2_CTRL_WR <= live && cp2w;
      CP2_CTRL_RD <= live && cp2r;
      if (live && (cp2w || cp2r)) begin
        CP2_CTRL_SEL <= rd;
        CP2_CTRL_WDATA <= rt_v;
      end
      // external status load overrides the instruction
      if (STATUS_LOAD)
        STATUS_WORD <= STATUS_DATA;
      else if (live && st_we)
        STATUS_WORD <= st_d;
      if (live && llop) begin
        RESERVE_FLAG <= 1'b1;
        RESERVE_ADDR <= rs_v + sext;
      end else if (live && exception_return_op) begin
        RESERVE_FLAG <= 1'b0;
      end
      // entry wins over a same-cycle return
      if (DEBUG_ENTER)
        DEBUG_MODE <= 1'b1;
      else if (live && debug_return_op)
        DEBUG_MODE <= 1'b0;
      if (div_done) begin
        RESULT_BOTTOM <= div_q;
        RESULT_TOP <= div_r;
      end
    end
  end

  div_unit #(
    .W  (32),
    .CW (6)
  ) u_div (
    .clk    (REF_CLK),
    .rst    (SRST),
    .start  (live && dstart),
    .sgn    (dsgn),
    .dvd    (rs_v),
    .dvs    (rt_v),
    .busy   (),
    .done_q (div_done),
    .quo_q  (div_q),
    .rem_q  (div_r)
  );
endmodule

// ### tb/cp2_mem_model.sv
/*
  Instruction memory and second coprocessor control file.
  The bench loads rom by hierarchical write before each reset.
*/
`timescale 1ns/10ps
module cp2_mem_model (
  input  wire        REF_CLK,
  input  wire [31:0] FETCH_PC,
  output wire        INSTR_VALID,
  output wire [31:0] INSTR_WORD,
  input  wire        CP2_CTRL_WR,
  input  wire        CP2_CTRL_RD,
  input  wire [4:0]  CP2_CTRL_SEL,
  input  wire [31:0] CP2_CTRL_WDATA,
  output wire [31:0] CP2_CTRL_RDATA
);
  logic [31:0] rom [64];
  logic [31:0] ctl [32];
  integer      k;
  initial begin
    for (k = 0; k < 32; k = k + 1)
      ctl[k] = 32'h00000000;
  end
  // word for the current pc always offered; empty words are no-ops
  assign INSTR_VALID = 1'b1;
  assign INSTR_WORD = rom[FETCH_PC[7:2]];
  always @(posedge REF_CLK) begin
    if (CP2_CTRL_WR)
      ctl[CP2_CTRL_SEL] <= CP2_CTRL_WDATA;
  end
  // control word returned; inverse outside a read so late samples fail
  assign CP2_CTRL_RDATA = CP2_CTRL_RD ? ctl[CP2_CTRL_SEL] : ~ctl[CP2_CTRL_SEL];
endmodule

// ### tb/isa_exec_chk.sv
/*
  Port-level assertions for the execution unit.
  Bound to every isa_exec_unit instance; sees only its ports.
*/
`timescale 1ns/10ps
`include "isa_exec_map.vh"
module isa_exec_chk #(
  parameter RESET_PC = 32'h00000000
) (
  input wire        REF_CLK,
  input wire        SRST,
  input wire [31:0] FETCH_PC,
  input wire        INSTR_VALID,
  input wire [31:0] INSTR_WORD,
  input wire        INSTR_READY,
  input wire        CP2_CTRL_WR,
  input wire        CP2_CTRL_RD,
  input wire [4:0]  CP2_CTRL_SEL,
  input wire [31:0] EXC_RET_PC,
  input wire [31:0] ERR_RET_PC,
  input wire [31:0] DBG_RET_PC,
  input wire        DEBUG_ENTER,
  input wire        DEBUG_MODE,
  input wire        HAZARD_BUSY,
  input wire        STATUS_LOAD,
  input wire [31:0] STATUS_WORD,
  input wire        RESERVE_FLAG
);
  reg  [31:0] w1_q, w2_q, p1_q, p2_q, st_q;
  wire        take = INSTR_VALID && INSTR_READY;
  wire        t_div = take && INSTR_WORD[31:26] == `OP_SPECIAL && INSTR_WORD[5:1] == 5'h0D;
  wire        t_ehb = take && INSTR_WORD == {21'h000000, `SA_BARRIER, 6'h00};
  wire        t_rd = take && INSTR_WORD[31:21] == {`OP_SECOND_COPROCESSOR, `RS_CTRL_RD};
  wire        t_wr = take && INSTR_WORD[31:21] == {`OP_SECOND_COPROCESSOR, `RS_CTRL_WR};
  wire        t_mf = take && INSTR_WORD[31:21] == {`OP_COP0, `RS_MFMC0} && !STATUS_LOAD;
  wire        t_er = take && INSTR_WORD == {`OP_COP0, 20'h80000, `FN_EXCEPTION_RETURN_OP} && !STATUS_LOAD;
  wire        t_dr = take && INSTR_WORD == {`OP_COP0, 20'h80000, `FN_DEBUG_RETURN_OP} && !DEBUG_ENTER;
  wire        t_beq = take && INSTR_WORD[31:16] == {`OP_BEQ, 10'h000};
  wire        t_ll = take && INSTR_WORD[31:26] == `OP_LINKLOAD;
  // history kept so branch targets can be judged two edges on
  always @(posedge REF_CLK) begin
    w1_q <= INSTR_WORD;
    w2_q <= w1_q;
    p1_q <= FETCH_PC;
    p2_q <= p1_q;
    st_q <= STATUS_WORD;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  AST_RESET: assert property ($fell(SRST) |-> FETCH_PC == RESET_PC && !RESERVE_FLAG
    && STATUS_WORD == `STATUS_RST && !DEBUG_MODE) else $error("bad state after reset");
  AST_DIV: assert property (t_div |=> (!INSTR_READY)[*8] ##25 !INSTR_READY ##1 INSTR_READY)
    else $error("divide stall length wrong");
  AST_BAR: assert property (t_ehb ##1 HAZARD_BUSY |=> !INSTR_READY)
    else $error("barrier issued while hazard busy");
  AST_CPRD: assert property (t_rd |=> CP2_CTRL_RD && !INSTR_READY
    && CP2_CTRL_SEL == w1_q[15:11] ##1 !CP2_CTRL_RD && INSTR_READY) else $error("ctrl read bad");
  AST_CPWR: assert property (t_wr |=> CP2_CTRL_WR && CP2_CTRL_SEL == w1_q[15:11])
    else $error("ctrl write bad");
  AST_IE: assert property (t_mf |=> STATUS_WORD[`ST_IE] == w1_q[5])
    else $error("interrupt enable not updated");
  AST_EXCEPTION_RETURN_OP: assert property (t_er |=> STATUS_WORD[2:1] == 2'h0 && !RESERVE_FLAG
    && FETCH_PC == (st_q[2] ? ERR_RET_PC : EXC_RET_PC)) else $error("exception return bad");
  AST_DRET: assert property (t_dr |=> !DEBUG_MODE && FETCH_PC == DBG_RET_PC)
    else $error("debug return bad");
  AST_DBG: assert property (DEBUG_ENTER |=> DEBUG_MODE) else $error("debug entry lost");
  AST_LL: assert property (t_ll |=> RESERVE_FLAG)
    else $error("reservation not set by linked load");
  AST_BEQ: assert property (t_beq ##1 take |=> FETCH_PC == p2_q + 32'h4
    + {{14{w2_q[15]}}, w2_q[15:0], 2'b00}) else $error("always branch target wrong");
endmodule
bind isa_exec_unit isa_exec_chk #(.RESET_PC(RESET_PC)) isa_exec_chk_i (
  .REF_CLK(REF_CLK), .SRST(SRST), .FETCH_PC(FETCH_PC), .INSTR_VALID(INSTR_VALID),
  .INSTR_WORD(INSTR_WORD), .INSTR_READY(INSTR_READY), .CP2_CTRL_WR(CP2_CTRL_WR),
  .CP2_CTRL_RD(CP2_CTRL_RD), .CP2_CTRL_SEL(CP2_CTRL_SEL), .EXC_RET_PC(EXC_RET_PC),
  .ERR_RET_PC(ERR_RET_PC), .DBG_RET_PC(DBG_RET_PC), .DEBUG_ENTER(DEBUG_ENTER),
  .DEBUG_MODE(DEBUG_MODE), .HAZARD_BUSY(HAZARD_BUSY), .STATUS_LOAD(STATUS_LOAD),
  .STATUS_WORD(STATUS_WORD), .RESERVE_FLAG(RESERVE_FLAG));

// ### tb/isa_exec_unit_bench.sv
/*
  Self-checking bench: three programs run from the memory model,
  results read back through the register observation port.
*/
`timescale 1ns/10ps
`include "isa_exec_map.vh"
module isa_exec_unit_bench;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg  [7:0]  cp2_cond = 8'h01;
  reg         debug_enter = 1'b0;
  reg         hazard_busy = 1'b0;
  reg  [4:0]  reg_sel = 5'h00;
  wire [31:0] fetch_pc, instr_word, cp2_wdata, cp2_rdata, status_word, reserve_addr;
  wire [31:0] result_top, result_bottom, reg_data;
  wire [4:0]  cp2_sel;
  wire        instr_valid, instr_ready, cp2_wr, cp2_rd, debug_mode, reserve_flag, exc_ovf;
  integer     failures = 0;
  integer     tests_run = 0;
  integer     ovf_n = 0;
  integer     i;
  reg  [15:0] hi [16];
  reg  [15:0] tk, lk;
  isa_exec_unit isa_exec_unit_i (
    .REF_CLK(clk), .SRST(srst), .FETCH_PC(fetch_pc), .INSTR_VALID(instr_valid),
    .INSTR_WORD(instr_word), .INSTR_READY(instr_ready), .CP2_COND(cp2_cond),
    .CP2_CTRL_WR(cp2_wr), .CP2_CTRL_RD(cp2_rd), .CP2_CTRL_SEL(cp2_sel),
    .CP2_CTRL_WDATA(cp2_wdata), .CP2_CTRL_RDATA(cp2_rdata), .EXC_RET_PC(32'h00000080),
    .ERR_RET_PC(32'h00000040), .DBG_RET_PC(32'h000000C0), .DEBUG_ENTER(debug_enter),
    .DEBUG_MODE(debug_mode), .HAZARD_BUSY(hazard_busy), .STATUS_LOAD(1'b0),
    .STATUS_DATA(32'h00000000), .STATUS_WORD(status_word), .RESERVE_FLAG(reserve_flag),
    .RESERVE_ADDR(reserve_addr), .EXC_OVERFLOW(exc_ovf), .RESULT_TOP(result_top),
    .RESULT_BOTTOM(result_bottom), .REG_SEL(reg_sel), .REG_DATA(reg_data));
  cp2_mem_model cp2_mem_model_i (
    .REF_CLK(clk), .FETCH_PC(fetch_pc), .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word),
    .CP2_CTRL_WR(cp2_wr), .CP2_CTRL_RD(cp2_rd), .CP2_CTRL_SEL(cp2_sel),
    .CP2_CTRL_WDATA(cp2_wdata), .CP2_CTRL_RDATA(cp2_rdata));
  always #20 clk = ~clk;
  // overflow pulses counted as they stand
  always @(posedge clk) begin
    if (exc_ovf === 1'b1)
      ovf_n = ovf_n + 1;
  end
  function [31:0] iw(input [5:0] op, input [4:0] rs, input [4:0] rt, input [15:0] im);
    iw = {op, rs, rt, im};
  endfunction
  function [31:0] rw(input [5:0] op, input [4:0] rs, input [4:0] rt, input [4:0] rd,
                     input [4:0] sa, input [5:0] fn);
    rw = {op, rs, rt, rd, sa, fn};
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input string what, input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task p(input integer a, input [31:0] w);
    cp2_mem_model_i.rom[a] = w;
  endtask
  task clear;
    integer k;
    for (k = 0; k < 64; k = k + 1)
      cp2_mem_model_i.rom[k] = 32'h00000000;
  endtask
  // reset four cycles; the program restarts from pc 0 with cleared registers
  task rst;
    srst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask
  // bounded wait for the fetch address; a hang ends the run
  task wait_pc(input [31:0] stop);
    integer n;
    for (n = 0; n < 3000 && fetch_pc !== stop; n = n + 1) begin
      @(posedge clk);
      #1;
    end
    if (fetch_pc !== stop) begin
      check("pc wait", fetch_pc, stop);
      complete_run;
    end
  endtask
  task chk_reg(input [4:0] idx, input [31:0] exp);
    reg_sel = idx;
    repeat (2) @(posedge clk);
    #1;
    check($sformatf("r%0d", idx), reg_data, exp);
  endtask
  initial begin
    // arithmetic, logic, counts, fields and unsigned divide
    clear;
    p(0, iw(`OP_WRAPPING_SUM_IMM_OP, 0, 1, 16'hFFFF));
    p(1, rw(`OP_SPECIAL, 1, 1, 2, 0, `FN_WRAPPING_SUM_OP));
    p(2, iw(`OP_CONJUNCTION_IMM_OP, 1, 3, 16'h8001));
    p(3, rw(`OP_SPECIAL2, 3, 7, 7, 0, `FN_CNT_ZERO));
    p(4, rw(`OP_SPECIAL2, 1, 8, 8, 0, `FN_CNT_ONE));
    p(5, rw(`OP_SPECIAL3, 1, 4, 30, 0, `FN_PULL));
    p(6, rw(`OP_SPECIAL, 4, 4, 5, 0, `FN_ADD));
    p(7, iw(`OP_SIGNED_SUM_IMM_OP, 4, 6, 16'h0001));
    p(8, iw(`OP_SIGNED_SUM_IMM_OP, 4, 9, 16'hFFFF));
    p(9, rw(`OP_SPECIAL3, 0, 2, 7, 4, `FN_DEPOSIT));
    p(10, rw(`OP_SPECIAL, 2, 3, 10, 0, `FN_AND));
    p(11, rw(`OP_SPECIAL, 1, 3, 0, 0, `FN_UNSIGNED_QUOTIENT_OP));
    p(12, rw(`OP_SPECIAL3, 3, 11, 3, 12, `FN_PULL));
    rst;
    ovf_n = 0;
    wait_pc(32'h00000038);
    chk_reg(1, 32'hFFFFFFFF);
    chk_reg(2, 32'hFFFFFF0E);
    chk_reg(3, 32'h00008001);
    chk_reg(4, 32'h7FFFFFFF);
    chk_reg(5, 32'h00000000);
    chk_reg(6, 32'h00000000);
    chk_reg(7, 32'h00000010);
    chk_reg(8, 32'h00000020);
    chk_reg(9, 32'h7FFFFFFE);
    chk_reg(10, 32'h00008000);
    chk_reg(11, 32'h00000008);
    check("overflow pulses", ovf_n, 32'h2);
    check("quotient", result_bottom, 32'h0001FFFC);
    check("remainder", result_top, 32'h00000003);
    $display("test arith done");
    // branch table: each entry is branch, slot, then a marker skipped when the branch is taken
    hi[0] = {`OP_BEQ, 10'h000};
    hi[1] = {`OP_BEQ, 5'h01, 5'h02};
    hi[2] = {`OP_BNE, 5'h01, 5'h02};
    hi[3] = {`OP_BRANCH_IF_NONPOS, 5'h02, 5'h00};
    hi[4] = {`OP_BRANCH_IF_NONPOS, 10'h000};
    hi[5] = {`OP_BRANCH_IF_POS, 5'h02, 5'h00};
    hi[6] = {`OP_BRANCH_IF_POS, 10'h000};
    hi[7] = {`OP_REGIMM, 5'h01, 5'h00};
    hi[8] = {`OP_REGIMM, 5'h01, 5'h01};
    hi[9] = {`OP_REGIMM, 5'h00, 5'h11};
    hi[10] = {`OP_REGIMM, 5'h02, 5'h10};
    hi[11] = {`OP_BEQL, 5'h01, 5'h02};
    hi[12] = {`OP_BGTZL, 5'h01, 5'h00};
    hi[13] = {`OP_SECOND_COPROCESSOR, 5'h08, 5'h01};
    hi[14] = {`OP_SECOND_COPROCESSOR, 5'h08, 5'h04};
    hi[15] = {`OP_SECOND_COPROCESSOR, 5'h08, 5'h07};
    tk = 16'h62B5;
    lk = 16'h9800;
    clear;
    p(0, iw(`OP_WRAPPING_SUM_IMM_OP, 0, 1, 16'hFFFF));
    p(1, iw(`OP_WRAPPING_SUM_IMM_OP, 0, 2, 16'h0001));
    for (i = 0; i < 16; i = i + 1) begin
      p(2 + 3 * i, {hi[i], 16'h0002});
      p(3 + 3 * i, iw(`OP_WRAPPING_SUM_IMM_OP, 20 + i / 8, 20 + i / 8, 16'h0001 << (i % 8)));
      p(4 + 3 * i, iw(`OP_WRAPPING_SUM_IMM_OP, 16 + i / 8, 16 + i / 8, 16'h0001 << (i % 8)));
    end
    rst;
    wait_pc(32'h000000C8);
    chk_reg(16, {24'h000000, ~tk[7:0]});
    chk_reg(17, {24'h000000, ~tk[15:8]});
    chk_reg(20, {24'h000000, ~(lk[7:0] & ~tk[7:0])});
    chk_reg(21, {24'h000000, ~(lk[15:8] & ~tk[15:8])});
    chk_reg(31, 4 * (2 + 3 * 10) + 8);
    $display("test branch done");
    // coprocessor moves, barrier, interrupts, linked load, returns, signed divide
    clear;
    p(0, iw(`OP_WRAPPING_SUM_IMM_OP, 0, 1, 16'h0064));
    p(1, iw(`OP_WRAPPING_SUM_IMM_OP, 0, 2, 16'hFFF9));
    p(2, rw(`OP_SECOND_COPROCESSOR, `RS_CTRL_WR, 1, 3, 0, 0));
    p(3, rw(`OP_SECOND_COPROCESSOR, `RS_CTRL_RD, 3, 3, 0, 0));
    p(4, rw(`OP_SPECIAL, 0, 0, 0, `SA_BARRIER, `FN_SHIFTL));
    p(5, rw(`OP_COP0, `RS_MFMC0, 4, 12, 0, 6'h00));
    p(6, rw(`OP_COP0, `RS_MFMC0, 5, 12, 0, 6'h20));
    p(7, iw(`OP_LINKLOAD, 1, 6, 16'h0010));
    p(8, rw(`OP_COP0, 5'h10, 0, 0, 0, `FN_EXCEPTION_RETURN_OP));
    p(16, rw(`OP_SPECIAL, 1, 2, 0, 0, `FN_DIV));
    p(17, rw(`OP_COP0, 5'h10, 0, 0, 0, `FN_EXCEPTION_RETURN_OP));
    p(32, rw(`OP_COP0, 5'h10, 0, 0, 0, `FN_DEBUG_RETURN_OP));
    hazard_busy = 1'b1;
    rst;
    debug_enter = 1'b1;
    @(posedge clk);
    #1;
    debug_enter = 1'b0;
    check("debug mode", debug_mode, 32'h1);
    wait_pc(32'h00000014);
    repeat (5) @(posedge clk);
    #1;
    check("stall pc", fetch_pc, 32'h00000014);
    check("stall ready", instr_ready, 32'h0);
    hazard_busy = 1'b0;
    wait_pc(32'h000000C0);
    check("debug left", debug_mode, 32'h0);
    chk_reg(3, 32'h00000064);
    chk_reg(4, 32'h00000004);
    chk_reg(5, 32'h00000004);
    check("status", status_word, 32'h00000001);
    check("reserve flag", reserve_flag, 32'h0);
    check("reserve addr", reserve_addr, 32'h00000074);
    check("quotient", result_bottom, 32'hFFFFFFF2);
    check("remainder", result_top, 32'h00000002);
    $display("test system done");
    complete_run;
  end
endmodule
